/* File: sleep_pkg.sv */
// Constants and types for the sleep and power-up sequencer
package sleep_pkg;

  // Timing
  localparam int CLK_FREQ_MHZ = 40;
  localparam int POR_DELAY_TIME_US = 2;
  localparam int POR_DELAY_CYCLES = POR_DELAY_TIME_US * CLK_FREQ_MHZ;
  localparam int POWER_UP_DELAY_TIME_US = 64000;
  localparam int POWER_UP_DELAY_CYCLES = POWER_UP_DELAY_TIME_US * CLK_FREQ_MHZ;
  localparam int PLL_LOCK_TIME_US = 2000;
  localparam int PLL_LOCK_CYCLES = PLL_LOCK_TIME_US * CLK_FREQ_MHZ;
  localparam int OSC_STARTUP_EDGES = 1024;

  // APB register map
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CAUSE_OFS = 8'h08;

  // Synchroniser reset: external reset pin idles high
  localparam logic [4:0] SYNC_RST_VAL = 5'h10;

  // Cycle phases, one-hot
  localparam logic [3:0] FIRST_CYCLE_PHASE = 4'h1;
  localparam logic [3:0] LAST_CYCLE_PHASE = 4'h8;

  typedef enum logic [2:0] {
    LOW_POWER_CRYSTAL_MODE = 3'h0,
    STANDARD_CRYSTAL_MODE = 3'h1,
    HIGH_SPEED_CRYSTAL_MODE = 3'h2,
    PLL_CRYSTAL_MODE = 3'h3,
    RESISTOR_CAPACITOR_OSC_MODE = 3'h4,
    RESISTOR_CAPACITOR_PORT_MODE = 3'h5,
    EXTERNAL_CLOCK_MODE = 3'h6,
    EXTERNAL_CLOCK_PORT_MODE = 3'h7
  } osc_mode_e;

  typedef enum logic [7:0] {
    ST_POWER_ON = 8'h01,
    ST_POR_DELAY = 8'h02,
    ST_PWR_DELAY = 8'h04,
    ST_OSC_START = 8'h08,
    ST_RUN = 8'h10,
    ST_SLEEP_PEND = 8'h20,
    ST_HALT = 8'h40,
    ST_EXT_RESET = 8'h80
  } seq_state_e;

  typedef struct packed {
    logic port_oe;
    logic port_data;
    logic power_up_delay_en;
    osc_mode_e mode;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{
    port_oe: 1'b0,
    port_data: 1'b0,
    power_up_delay_en: 1'b1,
    mode: HIGH_SPEED_CRYSTAL_MODE
  };

  typedef struct packed {
    logic irq_wake;
    logic wdt;
    logic ext;
    logic brownout;
    logic power_on;
  } cause_s;

  localparam cause_s CAUSE_RST = 5'h00;

  typedef struct packed {
    logic port_in;
    logic halted;
    logic [3:0] phase;
    seq_state_e state;
  } status_s;

endpackage : sleep_pkg

/* File: sync2.sv */
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  if (W < 1)
  begin : g_chk
    $error("sync2: W must be at least 1");
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sync2

/* File: delay_timer.sv */
// Down counter that times the power-up and start-up delays
`timescale 1ns/10ps
module delay_timer #(
  parameter int W = 22
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic tick,
  // Expiry pulse
  output logic done
);

  logic [W-1:0] cnt_r;

  if (W < 2)
  begin : g_chk
    $error("delay_timer: W must be at least 2");
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cnt_r <= '0;
    else if (load)
      cnt_r <= load_val;
    else if (tick && cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      done <= 1'b0;
    else
      done <= !load && tick && cnt_r == W'(1);
  end

endmodule : delay_timer

/* File: sleep_powerup_sequencer.sv */
// Sleep entry and wake, power-up delay sequencing and oscillator pin control
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/10ps
// Overview of operation
// (R1) Halt stops core clocks and oscillator
// (R2) Halted core frozen at first cycle phase
// (R3) Wake on external reset, watchdog or interrupt
// (R4) Power-up delay only after power-on or brown-out
// (R5) Start-up timer holds reset until oscillator stable
// (R6) PLL mode: power-on delay, power-up delay, start-up
// (R7) PLL mode adds nominal two milliseconds for lock
// (R8) Resistor or clock-in modes halted: output pin low
// (R9) Port modes: output pin is port bit six
// (R10) Crystal modes halted: both pins quiescent
// (R11) Wake restarts oscillator, crystal modes wait before execution
module sleep_powerup_sequencer #(
  parameter int unsigned POWER_UP_DELAY_CYCLES = sleep_pkg::POWER_UP_DELAY_CYCLES,
  parameter int unsigned PLL_LOCK_CYCLES = sleep_pkg::PLL_LOCK_CYCLES,
  parameter int CNT_W = 22
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sleep_pkg::ADDR_W-1:0] paddr,
  input wire logic [sleep_pkg::DATA_W-1:0] pwdata,
  output logic [sleep_pkg::DATA_W-1:0] prdata_r,
  output logic pready_r,
  output logic pslverr_r,
  // Core handshake
  input wire logic sleep_exec,
  input wire logic irq_wake,
  input wire logic wdt_reset,
  output logic core_clk_en_r,
  output logic chip_reset_r,
  output logic halted_r,
  output logic [3:0] phase_r,
  output logic osc_enable_r,
  // Asynchronous reset and supply events
  input wire logic ext_reset_n,
  input wire logic por_event,
  input wire logic brownout_reset_event,
  // Oscillator pins
  input wire logic oscillator_input_pin_in,
  output logic oscillator_input_pin_out_r,
  output logic oscillator_input_pin_oe_r,
  input wire logic oscillator_output_pin_in,
  output logic oscillator_output_pin_out_r,
  output logic oscillator_output_pin_oe_r
);

  logic ext_reset_n_s;
  logic por_s;
  logic brownout_s;
  logic osc_in_s;
  logic osc_out_s;
  logic osc_in_d_r;
  logic osc_edge;
  logic pwr_evt;
  logic xrst;
  sleep_pkg::seq_state_e state_r;
  sleep_pkg::seq_state_e state_nxt;
  sleep_pkg::ctrl_s ctrl_r;
  sleep_pkg::cause_s cause_r;
  sleep_pkg::cause_s cause_set;
  sleep_pkg::cause_s cause_clr;
  sleep_pkg::status_s status;
  logic crystal;
  logic pll_mode;
  logic port_mode;
  logic hold_rst_r;
  logic hold_nxt;
  logic osc_cold_r;
  logic tmr_load;
  logic tmr_tick;
  logic tmr_done;
  logic [CNT_W-1:0] tmr_val;
  logic running_nxt;
  logic halted_nxt;
  logic rst_nxt;
  logic [3:0] phase_nxt;
  logic setup;
  logic wr_en;
  logic rd_hit;
  logic [sleep_pkg::DATA_W-1:0] rd_mux;
  logic [31:0] delay_cnt_h;

  if (CNT_W < 2 || CNT_W > 30 || POWER_UP_DELAY_CYCLES < 1 || PLL_LOCK_CYCLES < 1 ||
      POWER_UP_DELAY_CYCLES + PLL_LOCK_CYCLES >= 2 ** CNT_W)
  begin : g_chk
    $error("sleep_powerup_sequencer: delay counts do not fit CNT_W");
  end

  sync2 #(
    .W(5),
    .RST_VAL(sleep_pkg::SYNC_RST_VAL)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({ext_reset_n, por_event, brownout_reset_event, oscillator_input_pin_in,
      oscillator_output_pin_in}),
    .sync_out({ext_reset_n_s, por_s, brownout_s, osc_in_s, osc_out_s})
  );

  delay_timer #(
    .W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .srst(srst),
    .load(tmr_load),
    .load_val(tmr_val),
    .tick(tmr_tick),
    .done(tmr_done)
  );

  // Oscillator edge detect for the start-up count
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      osc_in_d_r <= 1'b0;
    else
      osc_in_d_r <= osc_in_s;
  end

  assign osc_edge = osc_in_s && !osc_in_d_r;

  // Mode and event decode
  assign crystal = ctrl_r.mode inside {sleep_pkg::LOW_POWER_CRYSTAL_MODE,
    sleep_pkg::STANDARD_CRYSTAL_MODE, sleep_pkg::HIGH_SPEED_CRYSTAL_MODE,
    sleep_pkg::PLL_CRYSTAL_MODE};
  assign pll_mode = ctrl_r.mode == sleep_pkg::PLL_CRYSTAL_MODE;
  assign port_mode = ctrl_r.mode inside {sleep_pkg::RESISTOR_CAPACITOR_PORT_MODE,
    sleep_pkg::EXTERNAL_CLOCK_PORT_MODE};
  assign pwr_evt = por_s || brownout_s;
  assign xrst = !ext_reset_n_s || wdt_reset;

  // Sequencer next state
  always_comb
  begin
    state_nxt = state_r;
    if (pwr_evt)
      state_nxt = sleep_pkg::ST_POWER_ON;
    else
    begin
      unique case (state_r)
        sleep_pkg::ST_POWER_ON:
          state_nxt = sleep_pkg::ST_POR_DELAY;
        sleep_pkg::ST_POR_DELAY:
          if (tmr_done)
          begin
            if (ctrl_r.power_up_delay_en || pll_mode)
              state_nxt = sleep_pkg::ST_PWR_DELAY; // R4 R6
            else if (crystal)
              state_nxt = sleep_pkg::ST_OSC_START; // R5
            else
              state_nxt = sleep_pkg::ST_RUN;
          end
        sleep_pkg::ST_PWR_DELAY:
          if (tmr_done)
            state_nxt = crystal ? sleep_pkg::ST_OSC_START : sleep_pkg::ST_RUN; // R6
        sleep_pkg::ST_OSC_START:
          if (xrst)
            state_nxt = sleep_pkg::ST_EXT_RESET;
          else if (tmr_done)
            state_nxt = sleep_pkg::ST_RUN; // R5
        sleep_pkg::ST_RUN:
          if (xrst)
            state_nxt = sleep_pkg::ST_EXT_RESET;
          else if (sleep_exec)
            state_nxt = sleep_pkg::ST_SLEEP_PEND;
        sleep_pkg::ST_SLEEP_PEND:
          if (xrst)
            state_nxt = sleep_pkg::ST_EXT_RESET;
          else if (phase_r == sleep_pkg::LAST_CYCLE_PHASE)
            state_nxt = sleep_pkg::ST_HALT; // R2
        sleep_pkg::ST_HALT:
          if (xrst)
            state_nxt = sleep_pkg::ST_EXT_RESET; // R3
          else if (irq_wake)
            state_nxt = crystal ? sleep_pkg::ST_OSC_START : sleep_pkg::ST_RUN; // R3 R11
        sleep_pkg::ST_EXT_RESET:
          if (!xrst)
            state_nxt = (osc_cold_r && crystal) ? sleep_pkg::ST_OSC_START
              : sleep_pkg::ST_RUN; // R11
        default:
          state_nxt = sleep_pkg::ST_POWER_ON;
      endcase
    end
  end

  // Timer loads on entry to each delay state
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val = '0;
    if (state_nxt != state_r)
    begin
      if (state_nxt == sleep_pkg::ST_POR_DELAY)
      begin
        tmr_load = 1'b1;
        tmr_val = CNT_W'(sleep_pkg::POR_DELAY_CYCLES); // R6
      end
      else if (state_nxt == sleep_pkg::ST_PWR_DELAY)
      begin
        tmr_load = 1'b1;
        tmr_val = (ctrl_r.power_up_delay_en ? CNT_W'(POWER_UP_DELAY_CYCLES) : '0) +
          (pll_mode ? CNT_W'(PLL_LOCK_CYCLES) : '0); // R4 R7
      end
      else if (state_nxt == sleep_pkg::ST_OSC_START)
      begin
        tmr_load = 1'b1;
        tmr_val = CNT_W'(sleep_pkg::OSC_STARTUP_EDGES); // R5 R11
      end
    end
  end

  // Start-up timer counts oscillator edges, others count clocks
  assign tmr_tick = (state_r == sleep_pkg::ST_OSC_START) ? osc_edge : 1'b1;

  assign hold_nxt = (state_nxt == sleep_pkg::ST_OSC_START && state_r != state_nxt)
    ? state_r != sleep_pkg::ST_HALT : hold_rst_r;
  assign running_nxt = state_nxt inside {sleep_pkg::ST_RUN, sleep_pkg::ST_SLEEP_PEND};
  assign halted_nxt = state_nxt == sleep_pkg::ST_HALT;
  assign rst_nxt = state_nxt inside {sleep_pkg::ST_POWER_ON, sleep_pkg::ST_POR_DELAY,
    sleep_pkg::ST_PWR_DELAY, sleep_pkg::ST_EXT_RESET} ||
    (state_nxt == sleep_pkg::ST_OSC_START && hold_nxt);
  assign phase_nxt = running_nxt ? {phase_r[2:0], phase_r[3]} : sleep_pkg::FIRST_CYCLE_PHASE;

  // Sequencer state and core controls
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_r <= sleep_pkg::ST_POWER_ON;
      phase_r <= sleep_pkg::FIRST_CYCLE_PHASE;
      halted_r <= 1'b0;
      core_clk_en_r <= 1'b0;
      osc_enable_r <= 1'b1;
      chip_reset_r <= 1'b1;
      hold_rst_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt; // R2
      halted_r <= halted_nxt;
      core_clk_en_r <= running_nxt; // R1 R11
      osc_enable_r <= !halted_nxt; // R1 R11
      chip_reset_r <= rst_nxt; // R5
      hold_rst_r <= hold_nxt;
    end
  end

  // Oscillator was stopped and must be timed again
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      osc_cold_r <= 1'b0;
    else if (state_r == sleep_pkg::ST_HALT)
      osc_cold_r <= 1'b1;
    else if (state_nxt == sleep_pkg::ST_RUN)
      osc_cold_r <= 1'b0;
  end

  // Oscillator output pin
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      oscillator_output_pin_out_r <= 1'b0;
      oscillator_output_pin_oe_r <= 1'b0;
    end
    else if (port_mode)
    begin
      oscillator_output_pin_out_r <= ctrl_r.port_data; // R9
      oscillator_output_pin_oe_r <= ctrl_r.port_oe; // R9
    end
    else if (crystal)
    begin
      oscillator_output_pin_out_r <= !halted_nxt && !osc_in_s; // R10
      oscillator_output_pin_oe_r <= !halted_nxt; // R10
    end
    else
    begin
      oscillator_output_pin_out_r <= !halted_nxt && (phase_nxt[2] || phase_nxt[3]); // R8
      oscillator_output_pin_oe_r <= 1'b1; // R8
    end
  end

  // Oscillator input pin is never driven
  always_ff @(posedge ref_clk)
  begin
    oscillator_input_pin_out_r <= 1'b0;
    oscillator_input_pin_oe_r <= 1'b0; // R8 R10
  end

  // Reset cause flags, write one to clear, set wins
  always_comb
  begin
    cause_set = '{irq_wake: halted_r && irq_wake, wdt: wdt_reset, ext: !ext_reset_n_s,
      brownout: brownout_s, power_on: por_s};
    cause_clr = sleep_pkg::CAUSE_RST;
    if (wr_en && paddr == sleep_pkg::CAUSE_OFS)
      cause_clr = sleep_pkg::cause_s'(pwdata[$bits(sleep_pkg::cause_s)-1:0]);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      cause_r <= sleep_pkg::CAUSE_RST;
    else
      cause_r <= sleep_pkg::cause_s'((cause_r & ~cause_clr) | cause_set);
  end

  // Control register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ctrl_r <= sleep_pkg::CTRL_RST;
    else if (wr_en && paddr == sleep_pkg::CTRL_OFS)
      ctrl_r <= sleep_pkg::ctrl_s'(pwdata[$bits(sleep_pkg::ctrl_s)-1:0]);
  end

  // APB read decode
  assign status = '{port_in: osc_out_s, halted: halted_r, phase: phase_r, state: state_r};
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite;

  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = '0;
    case (paddr)
      sleep_pkg::CTRL_OFS:
        rd_mux = sleep_pkg::DATA_W'(ctrl_r);
      sleep_pkg::STATUS_OFS:
        rd_mux = sleep_pkg::DATA_W'(status);
      sleep_pkg::CAUSE_OFS:
        rd_mux = sleep_pkg::DATA_W'(cause_r);
      default:
        rd_hit = 1'b0;
    endcase
  end

  // APB answer in the first access cycle
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !rd_hit;
      if (setup)
        prdata_r <= pwrite ? '0 : rd_mux;
    end
  end

  // Cycles spent in the power-up delay
  always_ff @(posedge ref_clk)
  begin
    if (srst || state_r != sleep_pkg::ST_PWR_DELAY)
      delay_cnt_h <= '0;
    else
      delay_cnt_h <= delay_cnt_h + 32'h1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  sequence pll_delay_end;
    state_r == sleep_pkg::ST_PWR_DELAY && pll_mode ##1 state_r != sleep_pkg::ST_PWR_DELAY;
  endsequence

  sequence irq_wake_hit;
    halted_r && irq_wake && !xrst && !pwr_evt && crystal;
  endsequence

  halt_clock_off_a: assert property ($rose(halted_r) |-> // R1
    $past(state_r) == sleep_pkg::ST_SLEEP_PEND && !core_clk_en_r && !osc_enable_r)
    else $error("Halt entered without stopping clocks");
  halt_phase_a: assert property ($rose(halted_r) |-> // R2
    phase_r == sleep_pkg::FIRST_CYCLE_PHASE && $past(phase_r) == sleep_pkg::LAST_CYCLE_PHASE)
    else $error("Halt not at first cycle phase");
  wake_exit_a: assert property (halted_r && (irq_wake || xrst) |=> !halted_r) // R3
    else $error("Wake cause did not leave halt");
  pwr_delay_src_a: assert property ($rose(state_r == sleep_pkg::ST_PWR_DELAY) |-> // R4
    $past(state_r) == sleep_pkg::ST_POR_DELAY)
    else $error("Power-up delay after a non power-on reset");
  osc_start_rst_a: assert property (state_r == sleep_pkg::ST_OSC_START && hold_rst_r |-> // R5
    chip_reset_r && !core_clk_en_r)
    else $error("Reset released during oscillator start-up");
  pll_order_a: assert property (pll_delay_end |-> // R6
    state_r inside {sleep_pkg::ST_OSC_START, sleep_pkg::ST_POWER_ON})
    else $error("PLL power-up delay not followed by start-up timer");
  pll_lock_time_a: assert property (state_r == sleep_pkg::ST_PWR_DELAY && pll_mode && // R7
    tmr_done |-> delay_cnt_h >= PLL_LOCK_CYCLES)
    else $error("PLL lock delay too short");
  rc_pin_low_a: assert property (halted_r && $stable(ctrl_r) && // R8
    ctrl_r.mode inside {sleep_pkg::RESISTOR_CAPACITOR_OSC_MODE, sleep_pkg::EXTERNAL_CLOCK_MODE}
    |-> oscillator_output_pin_oe_r && !oscillator_output_pin_out_r && !oscillator_input_pin_oe_r)
    else $error("Output pin not low while halted");
  port_bit_a: assert property (port_mode |=> // R9
    oscillator_output_pin_out_r == $past(ctrl_r.port_data) &&
    oscillator_output_pin_oe_r == $past(ctrl_r.port_oe))
    else $error("Output pin not following port bit");
  xtal_quiet_a: assert property (halted_r && crystal && $stable(ctrl_r) |-> // R10
    !oscillator_output_pin_oe_r && !oscillator_input_pin_oe_r)
    else $error("Crystal pins driven while halted");
  wake_restart_a: assert property (irq_wake_hit |=> // R11
    state_r == sleep_pkg::ST_OSC_START && osc_enable_r && !core_clk_en_r && !chip_reset_r)
    else $error("Wake did not restart and time the oscillator");

endmodule : sleep_powerup_sequencer

/* File: osc_partner.sv */
// Crystal and pin model at the far side of the oscillator pins
`timescale 1ns/10ps
module osc_partner #(
  parameter int HALF = 2
)(
  // Clock
  input wire logic ref_clk,
  // Oscillator control and pins
  input wire logic osc_enable,
  output logic osc_in,
  input wire logic out_pin,
  input wire logic out_oe,
  output logic out_level
);
  int cnt = 0;
  logic last_out = 1'b0;
  initial
  begin
    osc_in = 1'b0;
  end
  // Crystal swings only while enabled, otherwise it stands still
  always @(posedge ref_clk)
  begin
    if (osc_enable)
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        osc_in <= ~osc_in;
    end
  end
  // A released pin shows the inverse of its last driven level
  always @(posedge ref_clk)
  begin
    if (out_oe)
      last_out <= out_pin;
  end
  assign out_level = out_oe ? out_pin : ~last_out;
endmodule : osc_partner

/* File: sleep_powerup_sequencer_tb.sv */
// Testbench for the sleep and power-up sequencer
`timescale 1ns/10ps
module sleep_powerup_sequencer_tb;
  localparam int HALF = 2;
  localparam int PUD = 20;
  localparam int PLL = 10;
  localparam int START = sleep_pkg::OSC_STARTUP_EDGES * 2 * HALF;
  localparam int POR_CYC = sleep_pkg::POR_DELAY_CYCLES;
  logic ref_clk, srst, psel, penable, pwrite, pready_r, pslverr_r;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_r, rd, ctrl, pb;
  logic sleep_exec, irq_wake, wdt_reset, core_clk_en_r, chip_reset_r, halted_r;
  logic [3:0] phase_r;
  logic osc_enable_r, ext_reset_n, por_event, brownout_reset_event, err;
  logic in_pin, in_out, in_oe, out_pin, out_out, out_oe;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n, cause, lo;
  logic xtal, port;

  sleep_powerup_sequencer #(
    .POWER_UP_DELAY_CYCLES(PUD),
    .PLL_LOCK_CYCLES(PLL)
  ) sleep_powerup_sequencer_inst (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
    .pslverr_r(pslverr_r), .sleep_exec(sleep_exec), .irq_wake(irq_wake),
    .wdt_reset(wdt_reset), .core_clk_en_r(core_clk_en_r), .chip_reset_r(chip_reset_r),
    .halted_r(halted_r), .phase_r(phase_r), .osc_enable_r(osc_enable_r),
    .ext_reset_n(ext_reset_n), .por_event(por_event),
    .brownout_reset_event(brownout_reset_event), .oscillator_input_pin_in(in_pin),
    .oscillator_input_pin_out_r(in_out), .oscillator_input_pin_oe_r(in_oe),
    .oscillator_output_pin_in(out_pin), .oscillator_output_pin_out_r(out_out),
    .oscillator_output_pin_oe_r(out_oe)
  );

  osc_partner #(
    .HALF(HALF)
  ) osc_partner_inst (
    .ref_clk(ref_clk), .osc_enable(osc_enable_r), .osc_in(in_pin),
    .out_pin(out_out), .out_oe(out_oe), .out_level(out_pin)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // Hang guard
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      n_fail++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready_r is seen high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready_r !== 1'b1)
      @(posedge ref_clk);
    rd = prdata_r;
    err = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_run;
    n = 0;
    while (core_clk_en_r !== 1'b1 && n < 6000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_run

  initial
  begin
    void'($urandom(32'h142c));
    {srst, psel, penable, pwrite, sleep_exec, irq_wake, wdt_reset} = 7'h40;
    {por_event, brownout_reset_event, ext_reset_n} = 3'h1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    wait_run();
    lo = POR_CYC + PUD + START - 4;
    check(n >= lo && n <= lo + 50, 1, "power-up time");
    check(chip_reset_r, 1'b0, "reset released");
    apb(1'b0, sleep_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h0000000a, "ctrl reset value");
    apb(1'b0, sleep_pkg::STATUS_OFS, 32'h0);
    check({rd[12], rd[7:0]}, 9'h010, "status run");
    apb(1'b1, 8'h0c, 32'hffffffff);
    check({31'h0, err}, 32'h1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    for (int m = 0; m < 8; m++)
    begin
      pb = $urandom;
      xtal = (m < 4);
      port = (m == 5 || m == 7);
      ctrl = {26'h0, pb[1:0], 1'b1, m[2:0]};
      apb(1'b1, sleep_pkg::CTRL_OFS, ctrl);
      @(posedge ref_clk);
      sleep_exec <= 1'b1;
      @(posedge ref_clk);
      sleep_exec <= 1'b0;
      repeat (6) if (halted_r !== 1'b1) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      check(halted_r, 1'b1, "halted");
      check({osc_enable_r, core_clk_en_r}, 2'b00, "clocks off");
      check(phase_r, sleep_pkg::FIRST_CYCLE_PHASE, "phase frozen");
      check({in_oe, in_out}, 2'b00, "input pin floating");
      check(out_oe, xtal ? 1'b0 : (port ? pb[1] : 1'b1), "output pin oe");
      if (!xtal && !port)
        check(out_out, 1'b0, "output pin low");
      if (port && pb[1])
      begin
        check(out_out, pb[0], "port bit six");
        apb(1'b0, sleep_pkg::STATUS_OFS, 32'h0);
        check(rd[13], pb[0], "port pin read back");
      end
      cause = $urandom_range(2);
      if (cause == 0)
        irq_wake <= 1'b1;
      else if (cause == 1)
        wdt_reset <= 1'b1;
      else
        ext_reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wdt_reset <= 1'b0;
      ext_reset_n <= 1'b1;
      wait_run();
      irq_wake <= 1'b0;
      if (xtal)
        check(n >= START - 8 && n <= START + 40, 1, "wake start-up");
      else
        check(n <= 12, 1, "wake prompt");
      check({halted_r, chip_reset_r, osc_enable_r}, 3'b001, "running");
    end
    for (int e = 0; e < 3; e++)
    begin
      apb(1'b1, sleep_pkg::CTRL_OFS, (e == 2) ? 32'h03 : 32'h0a);
      if (e == 0)
        por_event <= 1'b1;
      else
        brownout_reset_event <= 1'b1;
      repeat (4) @(posedge ref_clk);
      por_event <= 1'b0;
      brownout_reset_event <= 1'b0;
      wait_run();
      lo = POR_CYC + ((e == 2) ? PLL : PUD) + START - 4;
      check(n >= lo && n <= lo + 60, 1, "supply event delay");
      apb(1'b0, sleep_pkg::CAUSE_OFS, 32'h0);
      check(rd[1:0], (e == 0) ? 2'b01 : 2'b10, "supply cause flag");
      apb(1'b1, sleep_pkg::CAUSE_OFS, 32'h1f);
      ext_reset_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      ext_reset_n <= 1'b1;
      wait_run();
      check(n <= 12, 1, "no delay after pin reset");
    end
    end_sim();
  end
endmodule : sleep_powerup_sequencer_tb
